// file: include/slfc_defs.svh
// Constants of the segment LCD frame control block: offsets, fields, resets.
// Assumes a 32-bit Avalon-MM slave port with byte addresses, one register a word.
`ifndef SLFC_DEFS_SVH
`define SLFC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SLFC_OFS_CTRL_A 6'h00
`define SLFC_OFS_CTRL_B 6'h04
`define SLFC_OFS_FRAME_RATE 6'h08
`define SLFC_OFS_CONTRAST 6'h0c
`define SLFC_OFS_STATUS 6'h10
`define SLFC_OFS_MEM0 6'h20
`define SLFC_OFS_MEM1 6'h24
`define SLFC_OFS_MEM2 6'h28
`define SLFC_OFS_MEM3 6'h2c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLFC_A_ENABLE 7
`define SLFC_A_LOWPWR 6
`define SLFC_A_FLAG 4
`define SLFC_A_IRQ_EN 3
`define SLFC_A_BLANK 0
`define SLFC_B_CLKSEL 7
`define SLFC_B_HALFBIAS 6
`define SLFC_B_DUTY_HI 5
`define SLFC_B_DUTY_LO 4
`define SLFC_B_PMASK_HI 2
`define SLFC_B_PMASK_LO 0
`define SLFC_B_WMASK 8'hf7
`define SLFC_A_WMASK 8'hc9
`define SLFC_FR_WMASK 8'h77
`define SLFC_CC_WMASK 8'h0f

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SLFC_CTRL_RESET 8'h00
`define SLFC_K_DEFAULT 3'h7
`define SLFC_K_THIRD 3'h5
`define SLFC_SEG_COUNT 25
`define SLFC_COM_COUNT 4

`endif

// file: include/slfc_pkg.sv
// Types shared by the segment LCD frame control block.
// Assumes slfc_defs.svh is compiled alongside for the numeric constants.
package slfc_pkg;
    // Duty selections of the duty field
    typedef enum logic [1:0] {SLFC_DUTY_STATIC, SLFC_DUTY_HALF, SLFC_DUTY_THIRD,
        SLFC_DUTY_QUARTER} slfc_duty_t;
    // Bias driven to the analog stage
    typedef enum logic [1:0] {SLFC_BIAS_STATIC, SLFC_BIAS_HALF, SLFC_BIAS_THIRD}
        slfc_bias_t;
    // Controller run state
    typedef enum logic {SLFC_IDLE, SLFC_RUN} slfc_state_t;
endpackage

// file: hdl/slfc_frame_timer.sv
// Frame timer: prescaler, clock divider and common sequencer.
// Assumes lcd_tick marks one LCD clock period in the core_clk domain.
`timescale 1ns/1ps
`include "slfc_defs.svh"
module slfc_frame_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic lcd_tick,
    input wire logic [2:0] prescale_sel,
    input wire logic [2:0] divide_code,
    input wire slfc_pkg::slfc_duty_t duty,
    output logic frame_tick,
    output logic [1:0] common_index
);
    import slfc_pkg::*;

    logic [11:0] ps_cnt_reg;
    logic [2:0] div_cnt_reg;
    logic [2:0] phase_reg;
    logic [11:0] tap_mask;
    logic ps_tick;
    logic div_tick;
    logic [2:0] phase_last;

    // ----------------------------------------------------------------
    // Tap and period decode
    // ----------------------------------------------------------------
    // N of 16..4096 as a low-bit mask of the ripple counter
    assign tap_mask = (prescale_sel == 3'h0) ? 12'h00f :
                      ((12'h020 << prescale_sel) - 12'h001);
    assign ps_tick = lcd_tick && ((ps_cnt_reg & tap_mask) == tap_mask);
    assign div_tick = ps_tick && (div_cnt_reg == divide_code);
    // K is 6 for 1/3 duty, 8 otherwise
    assign phase_last = (duty == SLFC_DUTY_THIRD) ? `SLFC_K_THIRD : `SLFC_K_DEFAULT;
    assign frame_tick = run && div_tick && (phase_reg == phase_last);

    // Commons stepped in order from zero, evenly over the K phases
    assign common_index = (duty == SLFC_DUTY_STATIC) ? 2'h0 :
                          (duty == SLFC_DUTY_HALF) ? {1'b0, phase_reg[2]} :
                          phase_reg[2:1];

    // ----------------------------------------------------------------
    // Counters, held cleared while stopped
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_cnt_reg <= 12'h000;
            div_cnt_reg <= 3'h0;
            phase_reg <= 3'h0;
        end else if (!run) begin
            ps_cnt_reg <= 12'h000;
            div_cnt_reg <= 3'h0;
            phase_reg <= 3'h0;
        end else begin
            if (lcd_tick) ps_cnt_reg <= ps_cnt_reg + 12'h001;
            if (ps_tick) div_cnt_reg <= div_tick ? 3'h0 : div_cnt_reg + 3'h1;
            if (div_tick) phase_reg <= (phase_reg == phase_last) ? 3'h0 : phase_reg + 3'h1;
        end
    end
endmodule

// file: hdl/slfc_top.sv
// Segment LCD frame control: registers, frame latching, flag, pin ownership.
// Assumes an Avalon-MM master on core_clk and an analog drive stage that
// turns the digital drive outputs into LCD voltage levels.
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "slfc_defs.svh"
module slfc_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic timer_osc_input_pin,
    input wire logic ext_clock_pin,
    input wire logic ext_clock_input_sel,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    output logic frame_irq,
    output logic display_enable,
    output logic [3:0] backplane_line_lcd_en,
    output logic [24:0] electrode_drive_pin_lcd_en,
    output logic [3:0] backplane_select,
    output logic [24:0] electrode_drive_data,
    output logic drive_ground_all,
    output logic low_power_waveform_active,
    output logic frame_polarity,
    output slfc_pkg::slfc_bias_t bias_mode,
    output logic [3:0] contrast_level
);
    import slfc_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    // Control register A fields
    logic display_enable_reg;
    logic low_power_waveform_sel_reg;
    logic frame_start_flag_reg;
    logic frame_start_flag_next;
    logic frame_irq_enable_reg;
    logic blank_request_reg;
    // Control register B fields
    logic clock_source_sel_reg;
    logic half_bias_sel_reg;
    logic [1:0] duty_sel_reg;
    logic [2:0] segment_pin_mask_reg;
    // Frame rate and contrast settings
    logic [2:0] prescale_sel_reg;
    logic [2:0] frame_divider_code_reg;
    logic [3:0] contrast_reg;
    // Display memory, one row per common
    logic [24:0] display_mem_reg [0:3];
    logic [24:0] display_lat_reg [0:3];
    // Working copies taken at the frame latch point, plus frame parity and the enable delay
    logic blank_lat_reg;
    logic lowpwr_lat_reg;
    logic [3:0] contrast_lat_reg;
    logic parity_reg;
    logic enable_d_reg;
    // Bus handshake
    logic ack_reg;
    logic [31:0] readdata_reg;
    logic [31:0] read_mux;
    logic wr_go;
    logic [31:0] wr_bits;
    logic [31:0] wr_mask;
    logic sel_a;
    logic sel_b;
    logic sel_fr;
    logic sel_cc;
    logic sel_st;
    logic [3:0] sel_mem;
    logic [7:0] ctrl_a_view;
    logic [7:0] ctrl_b_view;
    // Asynchronous clock path
    logic async_pin;
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic async_level_reg;
    logic async_rise;
    logic lcd_tick;
    // Frame timing
    slfc_duty_t duty;
    logic frame_tick;
    logic [1:0] common_index;
    logic start_latch;
    logic frame_event;
    logic latch_now;
    logic flag_clear;
    logic [4:0] seg_count;
    logic [24:0] seg_en;
    logic [3:0] com_en;
    logic [3:0] com_onehot;
    slfc_state_t state;
    // Drive outputs held in flip-flops
    logic [3:0] backplane_select_reg;
    logic [24:0] electrode_drive_data_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // One wait cycle on every access; the access completes on the next edge
    assign waitrequest = (read || write) && !ack_reg;
    assign wr_go = write && ack_reg;
    assign readdata = readdata_reg;
    assign sel_a = (address == `SLFC_OFS_CTRL_A);
    assign sel_b = (address == `SLFC_OFS_CTRL_B);
    assign sel_fr = (address == `SLFC_OFS_FRAME_RATE);
    assign sel_cc = (address == `SLFC_OFS_CONTRAST);
    assign sel_st = (address == `SLFC_OFS_STATUS);
    assign sel_mem[0] = (address == `SLFC_OFS_MEM0);
    assign sel_mem[1] = (address == `SLFC_OFS_MEM1);
    assign sel_mem[2] = (address == `SLFC_OFS_MEM2);
    assign sel_mem[3] = (address == `SLFC_OFS_MEM3);
    // Byte enables gate each lane of a write
    assign wr_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
                      {8{byteenable[0]}}};
    assign wr_bits = writedata & wr_mask;

    // Reserved bits are simply not stored, so they read zero
    assign ctrl_a_view = {display_enable_reg, low_power_waveform_sel_reg, 1'b0,
                          frame_start_flag_reg, frame_irq_enable_reg, 2'b00,
                          blank_request_reg};
    assign ctrl_b_view = {clock_source_sel_reg, half_bias_sel_reg, duty_sel_reg, 1'b0,
                          segment_pin_mask_reg};

    // Read selection; unmapped addresses answer zero
    assign read_mux = sel_a ? {24'h000000, ctrl_a_view} :
                      sel_b ? {24'h000000, ctrl_b_view} :
                      sel_fr ? {24'h000000, 1'b0, prescale_sel_reg, 1'b0,
                                frame_divider_code_reg} :
                      sel_cc ? {28'h0000000, contrast_reg} :
                      sel_st ? {24'h000000, 1'b0, parity_reg, blank_lat_reg,
                                lowpwr_lat_reg, 2'b00, common_index} :
                      sel_mem[0] ? {7'h00, display_mem_reg[0]} :
                      sel_mem[1] ? {7'h00, display_mem_reg[1]} :
                      sel_mem[2] ? {7'h00, display_mem_reg[2]} :
                      sel_mem[3] ? {7'h00, display_mem_reg[3]} :
                      32'h00000000;

    // Handshake state and read data capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            readdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= (read || write) && !ack_reg;
            if (read && !ack_reg) readdata_reg <= read_mux;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Written fields of register A; a write to the flag bit is handled apart
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            display_enable_reg <= 1'(`SLFC_CTRL_RESET >> 7);
            low_power_waveform_sel_reg <= 1'b0;
            frame_irq_enable_reg <= 1'b0;
            blank_request_reg <= 1'b0;
        end else if (wr_go && sel_a && byteenable[0]) begin
            display_enable_reg <= writedata[`SLFC_A_ENABLE];
            low_power_waveform_sel_reg <= writedata[`SLFC_A_LOWPWR];
            frame_irq_enable_reg <= writedata[`SLFC_A_IRQ_EN];
            blank_request_reg <= writedata[`SLFC_A_BLANK];
        end
    end

    // Register B, frame rate and contrast settings
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_source_sel_reg <= 1'b0;
            half_bias_sel_reg <= 1'b0;
            duty_sel_reg <= 2'h0;
            segment_pin_mask_reg <= 3'h0;
            prescale_sel_reg <= 3'h0;
            frame_divider_code_reg <= 3'h0;
            contrast_reg <= 4'h0;
        end else if (wr_go && byteenable[0]) begin
            if (sel_b) begin
                clock_source_sel_reg <= writedata[`SLFC_B_CLKSEL];
                half_bias_sel_reg <= writedata[`SLFC_B_HALFBIAS];
                duty_sel_reg <= writedata[`SLFC_B_DUTY_HI:`SLFC_B_DUTY_LO];
                segment_pin_mask_reg <= writedata[`SLFC_B_PMASK_HI:`SLFC_B_PMASK_LO];
            end
            if (sel_fr) begin
                prescale_sel_reg <= writedata[6:4];
                frame_divider_code_reg <= writedata[2:0];
            end
            if (sel_cc) contrast_reg <= writedata[3:0];
        end
    end

    // Display memory rows, written lane by lane
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < `SLFC_COM_COUNT; r++) begin
                display_mem_reg[r] <= 25'h0000000;
            end
        end else begin
            for (int r = 0; r < `SLFC_COM_COUNT; r++) begin
                if (wr_go && sel_mem[r]) begin
                    display_mem_reg[r] <= (display_mem_reg[r] & ~wr_mask[24:0]) |
                                          wr_bits[24:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // LCD clock source
    // ----------------------------------------------------------------
    // Both pins are asynchronous, so muxing ahead of the synchroniser is safe
    assign async_pin = ext_clock_input_sel ? ext_clock_pin : timer_osc_input_pin;

    // Three-stage sampling; the level moves only when stages two and three agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            async_level_reg <= 1'b0;
        end else begin
            sync1_reg <= async_pin;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg) async_level_reg <= sync3_reg;
        end
    end

    // The async clock must be well below core_clk/4 to be seen at all
    assign async_rise = (sync2_reg == sync3_reg) && sync3_reg && !async_level_reg;
    assign lcd_tick = clock_source_sel_reg ? async_rise : 1'b1;

    // ----------------------------------------------------------------
    // Frame timing
    // ----------------------------------------------------------------
    assign duty = slfc_duty_t'(duty_sel_reg);
    assign state = display_enable_reg ? SLFC_RUN : SLFC_IDLE;

    slfc_frame_timer u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(state == SLFC_RUN),
        .lcd_tick(lcd_tick),
        .prescale_sel(prescale_sel_reg),
        .divide_code(frame_divider_code_reg),
        .duty(duty),
        .frame_tick(frame_tick),
        .common_index(common_index)
    );

    // First latch at enable so the first frame shows current data
    assign start_latch = display_enable_reg && !enable_d_reg;
    // In low-power mode only every second frame boundary counts
    assign frame_event = frame_tick && (!lowpwr_lat_reg || parity_reg);
    assign latch_now = start_latch || frame_event;

    // Working latches and frame parity
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_d_reg <= 1'b0;
            parity_reg <= 1'b0;
            blank_lat_reg <= 1'b0;
            lowpwr_lat_reg <= 1'b0;
            contrast_lat_reg <= 4'h0;
            for (int r = 0; r < `SLFC_COM_COUNT; r++) begin
                display_lat_reg[r] <= 25'h0000000;
            end
        end else begin
            enable_d_reg <= display_enable_reg;
            if (!display_enable_reg) parity_reg <= 1'b0;
            else if (frame_tick) parity_reg <= !parity_reg;
            if (latch_now) begin
                blank_lat_reg <= blank_request_reg;
                lowpwr_lat_reg <= low_power_waveform_sel_reg;
                contrast_lat_reg <= contrast_reg;
                for (int r = 0; r < `SLFC_COM_COUNT; r++) begin
                    display_lat_reg[r] <= display_mem_reg[r];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Frame flag and interrupt
    // ----------------------------------------------------------------
    assign flag_clear = irq_vector_taken ||
                        (wr_go && sel_a && byteenable[0] && writedata[`SLFC_A_FLAG]);
    // A new frame wins over a clear in the same cycle
    assign frame_start_flag_next = frame_event ||
                                   (frame_start_flag_reg && !flag_clear);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_start_flag_reg <= 1'b0;
        end else begin
            frame_start_flag_reg <= frame_start_flag_next;
        end
    end

    assign frame_irq = frame_start_flag_reg && frame_irq_enable_reg &&
                       global_irq_enable;

    // ----------------------------------------------------------------
    // Pin ownership
    // ----------------------------------------------------------------
    // Segment count 13,15,...,23,24,25 from the three-bit mask
    assign seg_count = (segment_pin_mask_reg == 3'h7) ? 5'd25 :
                       (segment_pin_mask_reg == 3'h6) ? 5'd24 :
                       5'd13 + {1'b0, segment_pin_mask_reg, 1'b0};

    // Per-segment ownership; a disabled controller releases every pin
    genvar gi;
    generate
        for (gi = 0; gi < `SLFC_SEG_COUNT; gi++) begin : g_seg
            assign seg_en[gi] = display_enable_reg && (5'(gi) < seg_count);
        end
    endgenerate

    // Commons in use follow the duty; the rest stay port pins
    assign com_en = !display_enable_reg ? 4'h0 :
                    (duty == SLFC_DUTY_STATIC) ? 4'h1 :
                    (duty == SLFC_DUTY_HALF) ? 4'h3 :
                    (duty == SLFC_DUTY_THIRD) ? 4'h7 : 4'hf;
    assign com_onehot = 4'h1 << common_index;

    assign display_enable = display_enable_reg;
    assign backplane_line_lcd_en = com_en;
    assign electrode_drive_pin_lcd_en = seg_en;

    // ----------------------------------------------------------------
    // Drive data
    // ----------------------------------------------------------------
    // Registered so the analog switches see glitch-free selects
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            backplane_select_reg <= 4'h0;
            electrode_drive_data_reg <= 25'h0000000;
        end else if (!display_enable_reg) begin
            backplane_select_reg <= 4'h0;
            electrode_drive_data_reg <= 25'h0000000;
        end else begin
            backplane_select_reg <= com_onehot;
            // A one energizes the segment against the addressed common
            electrode_drive_data_reg <= display_lat_reg[common_index] & seg_en;
        end
    end

    assign backplane_select = backplane_select_reg;
    assign electrode_drive_data = electrode_drive_data_reg;
    assign drive_ground_all = display_enable_reg && blank_lat_reg;
    assign low_power_waveform_active = lowpwr_lat_reg;
    assign frame_polarity = parity_reg;
    assign contrast_level = contrast_lat_reg;

    // Static duty always forces static bias, whatever the bias bit says
    assign bias_mode = (duty == SLFC_DUTY_STATIC) ? SLFC_BIAS_STATIC :
                       half_bias_sel_reg ? SLFC_BIAS_HALF : SLFC_BIAS_THIRD;
endmodule

// file: test/slfc_monitor.sv
// Concurrent checks on the ports of the frame control top.
// Assumes one clock domain and is bound onto every slfc_top instance.
`timescale 1ns/1ps
module slfc_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic global_irq_enable,
    input wire logic frame_irq,
    input wire logic display_enable,
    input wire logic [3:0] backplane_line_lcd_en,
    input wire logic [24:0] electrode_drive_pin_lcd_en,
    input wire logic [3:0] backplane_select,
    input wire logic drive_ground_all,
    input wire slfc_pkg::slfc_bias_t bias_mode
);
    import slfc_pkg::*;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_req_start; $rose(read || write); endsequence
    sequence s_one_wait; waitrequest ##1 !waitrequest; endsequence
    sequence s_com_moved;
        backplane_select != $past(backplane_select) && $past(backplane_select) != 4'h0;
    endsequence
    a_bus_one_wait: assert property (s_req_start |-> s_one_wait)
        else $error("bus access did not take exactly one wait cycle");
    a_irq_needs_global: assert property (frame_irq |-> global_irq_enable)
        else $error("frame interrupt without global enable");
    a_off_port_pins: assert property (!display_enable |->
        (backplane_line_lcd_en == 4'h0 && electrode_drive_pin_lcd_en == 25'h0))
        else $error("pins kept by display while disabled");
    a_off_stops_now: assert property ($fell(display_enable) |-> ##2 backplane_select == 4'h0)
        else $error("commons still addressed after disable");
    a_com_onehot: assert property ($onehot0(backplane_select))
        else $error("more than one common addressed");
    a_com_in_order: assert property (s_com_moved and backplane_select != 4'h0 |->
        backplane_select == ($past(backplane_select) << 1) || backplane_select == 4'h1)
        else $error("commons addressed out of order");
    a_blank_needs_on: assert property (drive_ground_all |-> display_enable)
        else $error("grounding while disabled");
    a_com_legal_set: assert property (display_enable |->
        backplane_line_lcd_en inside {4'h1, 4'h3, 4'h7, 4'hf})
        else $error("illegal common ownership");
    a_seg_legal_set: assert property (display_enable |-> (&electrode_drive_pin_lcd_en[12:0]) &&
        (electrode_drive_pin_lcd_en & (electrode_drive_pin_lcd_en + 25'h1)) == 25'h0)
        else $error("illegal segment ownership");
    a_bias_static: assert property (display_enable && backplane_line_lcd_en == 4'h1 |->
        bias_mode == SLFC_BIAS_STATIC)
        else $error("static duty without static bias");
endmodule
bind slfc_top slfc_monitor mon_u (.core_clk(core_clk), .rst_n(rst_n), .read(read),
    .write(write), .waitrequest(waitrequest), .global_irq_enable(global_irq_enable),
    .frame_irq(frame_irq), .display_enable(display_enable),
    .backplane_line_lcd_en(backplane_line_lcd_en),
    .electrode_drive_pin_lcd_en(electrode_drive_pin_lcd_en),
    .backplane_select(backplane_select), .drive_ground_all(drive_ground_all),
    .bias_mode(bias_mode));

// file: test/slfc_panel_model.sv
// Passive glass model: remembers what common 0 shows.
// Assumes digital drive outputs of the controller, no analog levels.
`timescale 1ns/1ps
module slfc_panel_model (
    input wire logic core_clk,
    input wire logic [3:0] backplane_select,
    input wire logic [24:0] electrode_drive_data,
    input wire logic drive_ground_all,
    output logic [24:0] lit_row0 = 25'h0
);
    // Grounded pins discharge the glass, so nothing stays lit
    always_ff @(posedge core_clk) begin
        if (drive_ground_all) begin
            lit_row0 <= 25'h0;
        end else if (backplane_select[0]) begin
            lit_row0 <= electrode_drive_data;
        end
    end
endmodule

// file: test/slfc_top_tb.sv
// Self-checking bench of the frame control block with a glass model.
// Assumes default frame rate: 128 cycles a frame on core_clk.
`timescale 1ns/1ps
`include "slfc_defs.svh"
module slfc_top_tb;
    import slfc_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, gie = 1'b1, vec = 1'b0;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic waitrequest, frame_irq, display_enable, gnd_all, lp_act;
    logic [3:0] com_en, com_sel;
    logic [24:0] seg_en, seg_data, lit_row0;
    slfc_bias_t bias;
    int error_cnt = 0, checked = 0, n;
    int segn[8] = '{13, 15, 17, 19, 21, 23, 24, 25};
    slfc_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .timer_osc_input_pin(1'b0), .ext_clock_pin(1'b0),
        .ext_clock_input_sel(1'b0), .global_irq_enable(gie), .irq_vector_taken(vec),
        .frame_irq(frame_irq), .display_enable(display_enable), .backplane_line_lcd_en(com_en),
        .electrode_drive_pin_lcd_en(seg_en), .backplane_select(com_sel),
        .electrode_drive_data(seg_data), .drive_ground_all(gnd_all),
        .low_power_waveform_active(lp_act), .frame_polarity(), .bias_mode(bias),
        .contrast_level());
    slfc_panel_model panel_u (.core_clk(core_clk), .backplane_select(com_sel),
        .electrode_drive_data(seg_data), .drive_ground_all(gnd_all), .lit_row0(lit_row0));
    always #20 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Requests stay up until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= ~w;
        do begin @(posedge core_clk); k++; end while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50) error_cnt++;
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic wait_irq;
        n = 0;
        while (frame_irq !== 1'b1 && n < 600) begin @(posedge core_clk); n++; end
        if (n >= 600) error_cnt++;
        @(negedge core_clk);
    endtask
    task automatic t_regs;
        bus(0, `SLFC_OFS_CTRL_A, 0); chk("ctrl_a", rd, 32'h0);
        bus(0, `SLFC_OFS_CTRL_B, 0); chk("ctrl_b", rd, 32'h0);
        bus(1, `SLFC_OFS_CTRL_A, 32'h26); bus(0, `SLFC_OFS_CTRL_A, 0); chk("a_rsv", rd, 32'h0);
        bus(1, `SLFC_OFS_CTRL_B, 32'h08); bus(0, `SLFC_OFS_CTRL_B, 0); chk("b_rsv", rd, 32'h0);
        bus(0, 6'h3c, 0); chk("unmapped", rd, 32'h0);
    endtask
    task automatic t_duty;
        for (int i = 0; i < 8; i++) begin
            bus(1, `SLFC_OFS_CTRL_B, (i[2] << 6) | (i[1:0] << 4) | i);
            bus(1, `SLFC_OFS_CTRL_A, 32'h80); chk("enable", display_enable, 1);
            chk("com_en", com_en, (32'h1 << (i[1:0] + 1)) - 1);
            chk("seg_en", seg_en, (32'h1 << segn[i]) - 1);
            chk("bias", bias, i[1:0] == 0 ? SLFC_BIAS_STATIC : i[2] ? SLFC_BIAS_HALF :
                SLFC_BIAS_THIRD);
            bus(1, `SLFC_OFS_CTRL_A, 0); chk("off_pins", {com_en, seg_en}, 0);
        end
    endtask
    task automatic t_frame;
        bus(1, `SLFC_OFS_MEM0, 32'h00abcdef);
        bus(1, `SLFC_OFS_CTRL_B, 32'h37);
        bus(1, `SLFC_OFS_CTRL_A, 32'h88); wait_irq;
        chk("frame_len", n inside {[120:136]}, 1);
        bus(0, `SLFC_OFS_CTRL_A, 0); chk("flag_set", rd[4], 1);
        chk("row0", lit_row0, 32'h00abcdef);
        @(posedge core_clk); gie <= 1'b0; @(negedge core_clk); chk("irq_gie", frame_irq, 0);
        @(posedge core_clk); gie <= 1'b1; @(negedge core_clk); chk("irq_on", frame_irq, 1);
        bus(1, `SLFC_OFS_CTRL_A, 32'h98); bus(0, `SLFC_OFS_CTRL_A, 0); chk("w1c", rd[4], 0);
        wait_irq;
        @(posedge core_clk); vec <= 1'b1; @(posedge core_clk); vec <= 1'b0;
        @(negedge core_clk); chk("vec_clr", frame_irq, 0);
    endtask
    task automatic t_lowpwr_blank;
        bus(1, `SLFC_OFS_CTRL_A, 32'hc8); chk("lp_wait", lp_act, 0);
        wait_irq; chk("lp_on", lp_act, 1);
        bus(1, `SLFC_OFS_CTRL_A, 32'hd8); wait_irq;
        bus(1, `SLFC_OFS_CTRL_A, 32'hd8); wait_irq; chk("lp_gap", n > 200, 1);
        bus(1, `SLFC_OFS_CTRL_A, 32'hd9); chk("blank_wait", gnd_all, 0);
        wait_irq; chk("blank", gnd_all, 1); chk("dark", lit_row0, 0);
        bus(1, `SLFC_OFS_CTRL_A, 32'h0); chk("off", display_enable, 0);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs; t_duty; t_frame; t_lowpwr_blank;
        print_verdict;
    end
    // Whole run needs about a thousand cycles; far longer means a hang
    initial begin
        #800000;
        error_cnt++;
        print_verdict;
    end
endmodule
